// >>> tws_serial_port.sv
// Three-wire serial port with APB register access
`timescale 1ns/1ps
module tws_serial_port
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic [tws_pkg::ADDR_W-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      serialClockPinIn,
  output logic                           serialClockPinOut,
  output logic                           serialClockPinOe,
  input  wire logic                      serialInPin,
  output logic                           serialOutPin,
  output logic                           serialOutPinOe,
  output logic                           transferDoneIrq
);
  import tws_pkg::*;

  typedef enum logic [0:0]
  {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } tws_xfer_state_t;

  tws_xfer_state_t xferState;
  tws_xfer_state_t next_xferState;

  tws_mode_t  serialPortMode;
  logic [7:0] transferShiftRegister;
  logic [3:0] bitCount;
  logic       busy;
  logic       loaded;
  logic       doneFlag;
  logic       sclkPrev;
  logic [1:0] pinSync;
  logic       genLevel;
  logic       genFall;
  logic       genRise;
  logic       genRiseDly;
  logic [3:0] next_bitCount;

  // Pin synchronisation
  tws_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn ({serialInPin, serialClockPinIn}),
    .syncOut (pinSync)
  );

  wire sclkSync = pinSync[0];
  wire sinSync  = pinSync[1];

  generate
    if (BITS_PER_UNIT != 8)
    begin : g_bad_unit
      $error("tws_serial_port: shift register holds exactly eight bits");
    end
  endgenerate

  // Internal clock
  wire genRun = busy & serialPortMode.clkInternal;
  // Pin clock takes the generator's next level, so it falls with the data change
  wire clkPinNext = genRun ? genLevel ^ (genFall | genRise) : 1'b1;

  tws_clk_gen u_clk_gen (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .run       (genRun),
    .rateSlow  (serialPortMode.rateSlow),
    .sclkLevel (genLevel),
    .fallPulse (genFall),
    .risePulse (genRise)
  );

  // Bus decode
  wire apbSetup  = psel & ~penable;
  wire apbWrite  = psel & penable & pready & pwrite;
  wire hitMode   = paddr == MODE_ADDR;
  wire hitShift  = paddr == SHIFT_ADDR;
  wire hitStatus = paddr == STATUS_ADDR;
  wire mapped    = hitMode | hitShift | hitStatus;

  wire modeWrite   = apbWrite & hitMode;
  wire shiftWrite  = apbWrite & hitShift;
  wire statusWrite = apbWrite & hitStatus;

  // Transfer control
  wire extLocked = loaded & ~serialPortMode.clkInternal;
  wire srLoad    = shiftWrite & ~busy & ~extLocked;
  wire clkReady  = serialPortMode.clkInternal | sclkSync;
  wire startXfer = srLoad & serialPortMode.enable & clkReady;

  wire extFall   = sclkPrev & ~sclkSync;
  wire extRise   = ~sclkPrev & sclkSync;
  wire sclkFall  = busy & (serialPortMode.clkInternal ? genFall : extFall);
  // Internal mode samples a cycle after the rise, once the input synchroniser caught up
  wire sclkRise  = busy & (serialPortMode.clkInternal ? genRiseDly : extRise);
  wire lastRise  = sclkRise & (bitCount == LAST_BIT);
  wire firstOut  = serialPortMode.lsbFirst ?
                   transferShiftRegister[0] : transferShiftRegister[7];

  wire [7:0] shiftedIn = serialPortMode.lsbFirst ?
                         {sinSync, transferShiftRegister[7:1]} :
                         {transferShiftRegister[6:0], sinSync};

  wire [7:0] modeNext = pwdata[7:0] & MODE_WR_MASK;

  wire [31:0] statusWord = {30'h0, doneFlag, busy};
  wire [31:0] readData = hitMode   ? {24'h0, serialPortMode} :
                         hitShift  ? {24'h0, transferShiftRegister} :
                         hitStatus ? statusWord : 32'h0;

  // APB answer, zero wait states
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~mapped;
    end
  end

  // Read data, valid in the access cycle only
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0;
    end
    else
    begin
      prdata <= apbSetup ? readData : 32'h0;
    end
  end

  // Mode register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serialPortMode <= tws_mode_t'(MODE_RESET);
    end
    else if (modeWrite)
    begin
      serialPortMode <= tws_mode_t'(modeNext);
    end
  end

  // Shift register, deliberately without reset
  always_ff @(posedge sys_clk)
  begin
    if (srLoad)
    begin
      transferShiftRegister <= pwdata[7:0];
    end
    else if (sclkRise)
    begin
      transferShiftRegister <= shiftedIn;
    end
  end

  // Transfer sequencing
  assign busy = xferState == XFER_SHIFT;

  always_comb
  begin
    next_xferState = xferState;
    next_bitCount  = bitCount;
    case (xferState)
      XFER_IDLE:
      begin
        next_bitCount = 4'h0;
        if (startXfer)
        begin
          next_xferState = XFER_SHIFT;
        end
      end
      XFER_SHIFT:
      begin
        if (!serialPortMode.enable)
        begin
          next_xferState = XFER_IDLE;
          next_bitCount  = 4'h0;
        end
        else if (lastRise)
        begin
          next_xferState = XFER_IDLE;
          next_bitCount  = 4'h0;
        end
        else if (sclkRise)
        begin
          next_bitCount = bitCount + 4'h1;
        end
      end
      default:
      begin
        next_xferState = XFER_IDLE;
        next_bitCount  = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xferState <= XFER_IDLE;
      bitCount  <= 4'h0;
      loaded    <= 1'b0;
    end
    else
    begin
      xferState <= next_xferState;
      bitCount  <= next_bitCount;
      loaded    <= next_xferState == XFER_SHIFT;
    end
  end

  // Edge history and delayed rise for sampling behind the synchroniser
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclkPrev   <= 1'b1;
      genRiseDly <= 1'b0;
    end
    else
    begin
      sclkPrev   <= sclkSync;
      genRiseDly <= genRise;
    end
  end

  // Done flag, set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      doneFlag <= 1'b0;
    end
    else if (lastRise)
    begin
      doneFlag <= 1'b1;
    end
    else if (statusWrite & pwdata[STAT_DONE_BIT])
    begin
      doneFlag <= 1'b0;
    end
  end

  // Done request, one cycle per transfer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      transferDoneIrq <= 1'b0;
    end
    else
    begin
      transferDoneIrq <= lastRise;
    end
  end

  // Output latch and data pin
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serialOutPin   <= 1'b0;
      serialOutPinOe <= 1'b0;
    end
    else
    begin
      serialOutPinOe <= serialPortMode.enable;
      if (sclkFall)
      begin
        serialOutPin <= firstOut;
      end
    end
  end

  // Clock pin
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serialClockPinOut <= 1'b1;
      serialClockPinOe  <= 1'b0;
    end
    else
    begin
      serialClockPinOut <= clkPinNext;
      serialClockPinOe  <= serialPortMode.enable & serialPortMode.clkInternal;
    end
  end

endmodule : tws_serial_port

// >>> tws_pkg.sv
// Constants, register map and types for the three-wire serial port
// Summary of operation
// - Transfers run only while enable bit set
// - Internal rate: oscillator divided by four or eight
// - Clock source: external pin input or internal output
// - First bit selectable, MSB or LSB
// - Reset clears mode register to zero
// - Shift register contents undefined after reset
// - Eight bits per transfer, full duplex
// - Falling clock edge drives next output bit
// - Rising clock edge captures input pin
// - Stop after eighth bit, raise done request
// - Write starts transfer only when enabled and idle
// - Data written while disabled is never sent
// - External clock: later writes ignored, data kept
// - Stop mode releases all three pins
// - Serial output is push-pull while enabled
package tws_pkg;

  localparam int unsigned SYS_CLK_HZ    = 10_000_000;
  localparam int unsigned BITS_PER_UNIT = 8;
  localparam int unsigned RATE_EXP_FAST = 2;
  localparam int unsigned RATE_EXP_SLOW = 3;
  localparam logic [3:0]  HALF_FAST     = 4'((1 << RATE_EXP_FAST) / 2);
  localparam logic [3:0]  HALF_SLOW     = 4'((1 << RATE_EXP_SLOW) / 2);
  localparam logic [3:0]  LAST_BIT      = 4'(BITS_PER_UNIT - 1);

  localparam int unsigned ADDR_W        = 18;
  localparam logic [15:0] MODE_INDEX    = 16'hFF72;
  localparam logic [15:0] SHIFT_INDEX   = 16'hFF74;
  localparam logic [15:0] STATUS_INDEX  = 16'hFF76;
  localparam logic [17:0] MODE_ADDR     = {MODE_INDEX, 2'b00};
  localparam logic [17:0] SHIFT_ADDR    = {SHIFT_INDEX, 2'b00};
  localparam logic [17:0] STATUS_ADDR   = {STATUS_INDEX, 2'b00};

  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  MODE_WR_MASK  = 8'h96;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;

  typedef struct packed {
    logic       enable;
    logic [1:0] unused65;
    logic       rateSlow;
    logic       unused3;
    logic       lsbFirst;
    logic       clkInternal;
    logic       unused0;
  } tws_mode_t;

endpackage : tws_pkg

// >>> tws_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tws_sync2
#(
  parameter int WIDTH = 2
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import tws_pkg::*;

  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("tws_sync2: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1  <= '1;
      syncOut <= '1;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : tws_sync2

// >>> tws_clk_gen.sv
// Internal serial clock generator, idles high
`timescale 1ns/1ps
module tws_clk_gen
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic rateSlow,
  output logic      sclkLevel,
  output logic      fallPulse,
  output logic      risePulse
);
  import tws_pkg::*;

  logic [3:0] halfCount;
  wire  [3:0] halfLimit = rateSlow ? HALF_SLOW : HALF_FAST;
  wire        halfDone  = halfCount == halfLimit - 4'h1;

  generate
    if (HALF_FAST < 4'h1)
    begin : g_bad_rate
      $error("tws_clk_gen: half period below one cycle");
    end
  endgenerate

  assign fallPulse = run & halfDone & sclkLevel;
  assign risePulse = run & halfDone & ~sclkLevel;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      halfCount <= 4'h0;
      sclkLevel <= 1'b1;
    end
    else if (!run)
    begin
      halfCount <= 4'h0;
      sclkLevel <= 1'b1;
    end
    else if (halfDone)
    begin
      halfCount <= 4'h0;
      sclkLevel <= ~sclkLevel;
    end
    else
    begin
      halfCount <= halfCount + 4'h1;
    end
  end

endmodule : tws_clk_gen

// >>> tws_serial_port_asserts.sv
// Port-level assertions for the serial port
`timescale 1ns/1ps
module tws_serial_port_asserts
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serialClockPinOut,
  input wire logic serialClockPinOe,
  input wire logic serialOutPin,
  input wire logic serialOutPinOe,
  input wire logic transferDoneIrq
);
  logic [3:0] nFall;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      nFall <= 4'h0;
    else if (transferDoneIrq || !serialClockPinOe)
      nFall <= 4'h0;
    else if ($fell(serialClockPinOut))
      nFall <= nFall + 4'h1;
  property p_done_on; !serialOutPinOe |-> !transferDoneIrq; endproperty
  a_done_on: assert property (p_done_on) else $error("done while off");
  property p_low; $fell(serialClockPinOut) |-> (!serialClockPinOut)[*2]; endproperty
  a_low: assert property (p_low) else $error("clock low too short");
  property p_eight; transferDoneIrq && serialClockPinOe |-> nFall == 4'h8; endproperty
  a_eight: assert property (p_eight) else $error("fall count wrong");
  property p_shift;
    serialClockPinOe && $stable(serialClockPinOe) && $changed(serialOutPin)
      |-> $fell(serialClockPinOut);
  endproperty
  a_shift: assert property (p_shift) else $error("data moved off fall");
  property p_pulse; transferDoneIrq |=> !transferDoneIrq; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_rel; !serialOutPinOe |-> !serialClockPinOe; endproperty
  a_rel: assert property (p_rel) else $error("clock driven while off");
  property p_idle; transferDoneIrq && serialClockPinOe |-> serialClockPinOut; endproperty
  a_idle: assert property (p_idle) else $error("clock not high at end");
  property p_drv; $fell(serialClockPinOut) |-> serialClockPinOe; endproperty
  a_drv: assert property (p_drv) else $error("clock pulse undriven");
endmodule : tws_serial_port_asserts
bind tws_serial_port tws_serial_port_asserts u_chk (.*);

// >>> tws_partner.sv
// Far-side serial peripheral model
`timescale 1ns/1ps
module tws_partner
(
  input  wire logic sclk,
  input  wire logic sdi,
  output logic      sdo,
  output logic      extClk
);
  logic [7:0] tx;
  logic [7:0] rx;
  initial extClk = 1'b1;
  initial sdo = 1'b0;
  always @(negedge sclk)
  begin
    sdo <= tx[7];
    tx <= {tx[6:0], ~tx[7]};
  end
  always @(posedge sclk) rx <= {rx[6:0], sdi};
  task automatic run(input int half);
    #50;
    repeat (8)
    begin
      #half extClk = 1'b0;
      #half extClk = 1'b1;
    end
  endtask : run
endmodule : tws_partner

// >>> tws_serial_port_bench.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tws_serial_port_bench;
  import tws_pkg::*;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        clkOut, clkOe, sdi, sdo, sdoOe, irq, pClk;
  int          fail_count, samples_checked, falls;
  wire         sclk = clkOe ? clkOut : pClk;
  tws_serial_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClockPinIn(sclk), .serialClockPinOut(clkOut),
    .serialClockPinOe(clkOe), .serialInPin(sdi), .serialOutPin(sdo),
    .serialOutPinOe(sdoOe), .transferDoneIrq(irq));
  tws_partner peer (.sclk(sclk), .sdi(sdo), .sdo(sdi), .extClk(pClk));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sclk) falls++;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic [7:0] m, d, pt, erx, erd, input int half);
    apb(1'b1, MODE_ADDR, m);
    peer.tx = pt;
    falls = 0;
    apb(1'b1, SHIFT_ADDR, d);
    if (half > 0)
    begin
      apb(1'b1, SHIFT_ADDR, 8'hFF);
      peer.run(half);
    end
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk(irq, 32'h1);
    chk(peer.rx, erx);
    apb(1'b0, STATUS_ADDR, 8'h00);
    chk(rd, 32'h2);
    apb(1'b1, STATUS_ADDR, 8'h02);
    apb(1'b0, STATUS_ADDR, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, SHIFT_ADDR, 8'h00);
    chk(rd, erd);
    chk(falls, 32'h8);
  endtask : xfer
  task automatic end_sim;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    #2_000_000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, MODE_ADDR, 8'h00);
    chk(rd, MODE_RESET);
    chk({clkOe, sdoOe, clkOut}, 3'b001);
    apb(1'b0, 18'h00000, 8'h00);
    chk(err, 1'b1);
    apb(1'b1, MODE_ADDR, 8'h96);
    apb(1'b0, MODE_ADDR, 8'h00);
    chk(rd, 32'h96);
    chk({clkOe, sdoOe}, 2'b11);
    apb(1'b1, MODE_ADDR, 8'h00);
    apb(1'b1, SHIFT_ADDR, 8'h55);
    falls = 0;
    apb(1'b1, MODE_ADDR, 8'h82);
    repeat (40) @(posedge sys_clk);
    chk(falls, 32'h0);
    xfer(8'h82, 8'hA5, 8'h3C, 8'hA5, 8'h3C, 0);
    xfer(8'h96, 8'h1E, 8'h35, 8'h78, 8'hAC, 0);
    xfer(8'h80, 8'h5A, 8'hC3, 8'h5A, 8'hC3, 500);
    end_sim;
  end
endmodule : tws_serial_port_bench
